// File: rab_pkg.sv
// Shared constants, types and carriers of the register access bank
package rab_pkg;

  // ----------------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  typedef logic [DATA_W-1:0] rab_data_t;
  typedef logic [ADDR_W-1:0] rab_addr_t;
  typedef logic [1:0]        rab_code_t;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam rab_addr_t ADDR_CTRL     = 3'h0;
  localparam rab_addr_t ADDR_STATUS   = 3'h1;
  localparam rab_addr_t ADDR_CMD      = 3'h2;
  localparam rab_addr_t ADDR_DBG      = 3'h3;
  localparam rab_addr_t ADDR_FLAG_CLR = 3'h4;
  localparam rab_addr_t ADDR_FLAG_SET = 3'h5;

  // ----------------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------------
  localparam rab_data_t CTRL_RW_MASK  = 8'h0f;
  localparam rab_data_t CTRL_RST      = 8'h00;
  localparam int        CTRL_EN_BIT   = 0;
  localparam int        CTRL_HALT_BIT = 1;
  localparam rab_data_t DBG_RW_MASK   = 8'h01;
  localparam rab_data_t DBG_RST       = 8'h00;
  localparam rab_data_t FLAG_RST      = 8'h00;
  localparam int        CMD_SRST_BIT  = 0;
  localparam int        CMD_KICK_BIT  = 1;
  localparam rab_data_t CMD_READ_VAL  = 8'h00;
  localparam rab_data_t UNMAPPED_VAL  = 8'h00;
  localparam logic [5:0] STATUS_PAD   = 6'h00;

  // Status state codes; the fourth encoding is reserved
  localparam rab_code_t CODE_IDLE = 2'h0;
  localparam rab_code_t CODE_RUN  = 2'h1;
  localparam rab_code_t CODE_HALT = 2'h2;
  localparam rab_code_t CODE_RSVD = 2'h3;

  // ----------------------------------------------------------------------
  // States and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } rab_state_e;

  typedef struct packed {
    logic      rd;
    rab_addr_t raddr;
    logic      wr0;
    rab_addr_t waddr0;
    rab_data_t wdata0;
    logic      wr1;
    rab_addr_t waddr1;
    rab_data_t wdata1;
  } rab_req_s;

  typedef struct packed {
    logic      rvalid;
    rab_data_t rdata;
  } rab_rsp_s;

endpackage

// File: rab_setclr.sv
// Shared bit state behind a set alias and a clear alias
`timescale 1ns/1ps
module rab_setclr (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst,
  // Bit actions
  input  wire logic           soft_rst,
  input  wire rab_pkg::rab_data_t set_mask,
  input  wire rab_pkg::rab_data_t clr_mask,
  // Shared state
  output rab_pkg::rab_data_t  state_q
);
  import rab_pkg::*;

  rab_data_t state_reg;
  rab_data_t state_next;

  // ----------------------------------------------------------------------
  // One cell per bit
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    // Clear is tested after soft reset but before set, so it beats a simultaneous set
    always_comb begin
      state_next[i] = state_reg[i];
      if (soft_rst) begin
        state_next[i] = FLAG_RST[i];
      end else if (clr_mask[i]) begin
        state_next[i] = 1'b0;
      end else if (set_mask[i]) begin
        state_next[i] = 1'b1;
      end
    end
  end

  // Register the shared bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= FLAG_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_q = state_reg;

endmodule // rab_setclr

// File: rab_regs.sv
// Register bank showing the shared bit access conventions
`timescale 1ns/1ps
module rab_regs (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Access port
  input  wire rab_pkg::rab_req_s req,
  output rab_pkg::rab_rsp_s      rsp,
  // Register contents seen by the peripheral
  output rab_pkg::rab_data_t     ctrl_q,
  output rab_pkg::rab_data_t     dbg_q,
  output rab_pkg::rab_data_t     flags_q,
  output rab_pkg::rab_state_e    state_q,
  // One-cycle strobe from the command register
  output logic                   kick
);
  import rab_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic wr, input rab_addr_t a,
                               input rab_addr_t t);
    return wr && (a == t);
  endfunction

  function automatic rab_code_t code_of(input rab_state_e s);
    case (s)
      ST_IDLE: return CODE_IDLE;
      ST_RUN:  return CODE_RUN;
      ST_HALT: return CODE_HALT;
      default: return CODE_IDLE;
    endcase
  endfunction

  rab_data_t  ctrl_reg;
  rab_data_t  ctrl_next;
  rab_data_t  dbg_reg;
  rab_data_t  dbg_next;
  rab_state_e state_reg;
  rab_state_e state_next;
  rab_rsp_s   rsp_reg;
  rab_rsp_s   rsp_next;
  logic       kick_reg;
  logic       kick_next;
  rab_data_t  flags;
  rab_data_t  set_mask;
  rab_data_t  clr_mask;
  logic       srst;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  // Both lanes may hit alias registers in one cycle
  always_comb begin
    clr_mask = '0;
    set_mask = '0;
    srst     = 1'b0;
    kick_next = 1'b0;
    if (hit(req.wr0, req.waddr0, ADDR_FLAG_CLR)) clr_mask |= req.wdata0;
    if (hit(req.wr1, req.waddr1, ADDR_FLAG_CLR)) clr_mask |= req.wdata1;
    if (hit(req.wr0, req.waddr0, ADDR_FLAG_SET)) set_mask |= req.wdata0;
    if (hit(req.wr1, req.waddr1, ADDR_FLAG_SET)) set_mask |= req.wdata1;
    // Command bits act and are not stored
    if (hit(req.wr0, req.waddr0, ADDR_CMD)) begin
      srst      |= req.wdata0[CMD_SRST_BIT];
      kick_next |= req.wdata0[CMD_KICK_BIT];
    end
    if (hit(req.wr1, req.waddr1, ADDR_CMD)) begin
      srst      |= req.wdata1[CMD_SRST_BIT];
      kick_next |= req.wdata1[CMD_KICK_BIT];
    end
    if (srst) begin
      kick_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control and debug registers
  // ----------------------------------------------------------------------
  // Lane 0 is applied last so it wins a same-register collision
  always_comb begin
    ctrl_next = ctrl_reg;
    dbg_next  = dbg_reg;
    if (hit(req.wr1, req.waddr1, ADDR_CTRL)) begin
      ctrl_next = req.wdata1 & CTRL_RW_MASK;
    end
    if (hit(req.wr0, req.waddr0, ADDR_CTRL)) begin
      ctrl_next = req.wdata0 & CTRL_RW_MASK;
    end
    if (hit(req.wr1, req.waddr1, ADDR_DBG)) begin
      dbg_next = req.wdata1 & DBG_RW_MASK;
    end
    if (hit(req.wr0, req.waddr0, ADDR_DBG)) begin
      dbg_next = req.wdata0 & DBG_RW_MASK;
    end
    // Debug settings survive a peripheral reset, but the whole control register is
    // cleared and any state falls to ST_IDLE when software restarts the block
    if (srst) begin
      ctrl_next = CTRL_RST;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      dbg_reg  <= DBG_RST;
      kick_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      dbg_reg  <= dbg_next;
      kick_reg <= kick_next;
    end
  end

  // ----------------------------------------------------------------------
  // Peripheral state machine behind the read-only status field
  // ----------------------------------------------------------------------
  // Writes to the status offset never reach this logic
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ctrl_reg[CTRL_EN_BIT]) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!ctrl_reg[CTRL_EN_BIT]) state_next = ST_IDLE;
        else if (ctrl_reg[CTRL_HALT_BIT]) state_next = ST_HALT;
      end
      ST_HALT: begin
        if (!ctrl_reg[CTRL_EN_BIT]) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (srst) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Set/clear pair
  // ----------------------------------------------------------------------
  rab_setclr u_flags (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .soft_rst (srst),
    .set_mask (set_mask),
    .clr_mask (clr_mask),
    .state_q  (flags)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Data is registered; answer arrives one cycle after the request
  always_comb begin
    rsp_next.rvalid = req.rd;
    case (req.raddr)
      ADDR_CTRL:     rsp_next.rdata = ctrl_reg;
      ADDR_STATUS:   rsp_next.rdata = {STATUS_PAD,
                                       code_of(state_reg)};
      ADDR_CMD:      rsp_next.rdata = CMD_READ_VAL;
      ADDR_DBG:      rsp_next.rdata = dbg_reg;
      ADDR_FLAG_CLR: rsp_next.rdata = flags;
      ADDR_FLAG_SET: rsp_next.rdata = flags;
      default:       rsp_next.rdata = UNMAPPED_VAL;
    endcase
    if (!req.rd) begin
      rsp_next.rdata = UNMAPPED_VAL;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp     = rsp_reg;
  assign ctrl_q  = ctrl_reg;
  assign dbg_q   = dbg_reg;
  assign flags_q = flags;
  assign state_q = state_reg;
  assign kick    = kick_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic ctrl_wr0;
  logic ctrl_any;
  assign ctrl_wr0 = hit(req.wr0, req.waddr0, ADDR_CTRL);
  assign ctrl_any = ctrl_wr0 || hit(req.wr1, req.waddr1, ADDR_CTRL);

  property p_rw_write;
    ctrl_wr0 && !srst |=> ctrl_reg == ($past(req.wdata0) & CTRL_RW_MASK);
  endproperty
  a_rw_write: assert property (p_rw_write)
    else $error("control write not stored");

  property p_rw_hold;
    !ctrl_any && !srst |=> $stable(ctrl_reg);
  endproperty
  a_rw_hold: assert property (p_rw_hold)
    else $error("control changed without a write");

  property p_ro_read;
    req.rd && req.raddr == ADDR_STATUS |=>
      rsp.rvalid && rsp.rdata == {STATUS_PAD, code_of($past(state_reg))};
  endproperty
  a_ro_read: assert property (p_ro_read)
    else $error("status read does not show live state");

  property p_rsvd_zero;
    req.rd && req.raddr == ADDR_CTRL |=>
      (rsp.rdata & ~CTRL_RW_MASK) == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved control bits read nonzero");

  property p_no_rsvd_code;
    req.rd && req.raddr == ADDR_STATUS |=> rsp.rdata[1:0] != CODE_RSVD;
  endproperty
  a_no_rsvd_code: assert property (p_no_rsvd_code)
    else $error("status shows reserved encoding");

  property p_srst;
    srst && !hit(req.wr0, req.waddr0, ADDR_DBG) &&
      !hit(req.wr1, req.waddr1, ADDR_DBG) |=>
      ctrl_reg == CTRL_RST && flags == FLAG_RST &&
      state_reg == ST_IDLE && $stable(dbg_reg);
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset result wrong");

  property p_clr;
    !srst |=> (flags & $past(clr_mask)) == 8'h00;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear alias did not clear");

  property p_set;
    !srst |=> (flags & ($past(set_mask) & ~$past(clr_mask))) ==
              ($past(set_mask) & ~$past(clr_mask));
  endproperty
  a_set: assert property (p_set)
    else $error("set alias did not set");

  property p_alias_same;
    req.rd && (req.raddr == ADDR_FLAG_CLR || req.raddr == ADDR_FLAG_SET)
      |=> rsp.rdata == $past(flags);
  endproperty
  a_alias_same: assert property (p_alias_same)
    else $error("alias read differs from shared state");

  property p_clr_wins;
    !srst && (set_mask & clr_mask) != 8'h00 |=>
      (flags & $past(set_mask) & $past(clr_mask)) == 8'h00;
  endproperty
  a_clr_wins: assert property (p_clr_wins)
    else $error("set beat clear");

  property p_zero_hold;
    !srst |=> (flags & ~($past(set_mask) | $past(clr_mask))) ==
              ($past(flags) & ~($past(set_mask) | $past(clr_mask)));
  endproperty
  a_zero_hold: assert property (p_zero_hold)
    else $error("untouched flag bit changed");

  c_clr_set: cover property ((set_mask & clr_mask) != 8'h00);
  c_srst:    cover property (srst ##1 ctrl_reg == CTRL_RST);
  c_halt:    cover property (state_reg == ST_RUN ##1 state_reg == ST_HALT);
  c_kick:    cover property (kick);

endmodule // rab_regs

// File: rab_regs_tb.sv
// Self-checking testbench of the register access bank
`timescale 1ns/1ps
module rab_regs_tb;
  import rab_pkg::*;

  // ----------------------------------------------------------------------
  // Compare helper
  // ----------------------------------------------------------------------
  `define CHK(nm, got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic       sys_clk;
  logic       rst;
  rab_req_s   req;
  rab_rsp_s   rsp;
  rab_data_t  ctrl_q;
  rab_data_t  dbg_q;
  rab_data_t  flags_q;
  rab_state_e state_q;
  logic       kick;
  int         num_errors;
  int         checks_done;
  int         cycles;
  rab_data_t  rv;
  rab_data_t  rv2;

  // Clock of 50 ns period
  always #25 sys_clk = ~sys_clk;

  rab_regs dut_u (
    .sys_clk (sys_clk),
    .rst     (rst),
    .req     (req),
    .rsp     (rsp),
    .ctrl_q  (ctrl_q),
    .dbg_q   (dbg_q),
    .flags_q (flags_q),
    .state_q (state_q),
    .kick    (kick)
  );

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  // Lane 0 write; returns just after the taking edge has landed
  // The bank holds no fuse location, so none is ever written
  task automatic wr(input rab_addr_t a, input rab_data_t d);
    @(posedge sys_clk);
    req.wr0    <= 1'b1;
    req.waddr0 <= a;
    req.wdata0 <= d;
    @(posedge sys_clk);
    req.wr0 <= 1'b0;
    #1;
  endtask

  // Both lanes in one cycle, for alias races and soft reset
  task automatic wr2(input rab_addr_t a0, input rab_data_t d0,
                     input rab_addr_t a1, input rab_data_t d1);
    @(posedge sys_clk);
    req.wr0    <= 1'b1;
    req.waddr0 <= a0;
    req.wdata0 <= d0;
    req.wr1    <= 1'b1;
    req.waddr1 <= a1;
    req.wdata1 <= d1;
    @(posedge sys_clk);
    req.wr0 <= 1'b0;
    req.wr1 <= 1'b0;
    #1;
  endtask

  // Read; response stands only in the cycle after the taking edge
  task automatic rd(input rab_addr_t a, output rab_data_t d);
    @(posedge sys_clk);
    req.rd    <= 1'b1;
    req.raddr <= a;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    `CHK("rvalid", rsp.rvalid, 1'b1)
    d = rsp.rdata;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Values right after power reset
  task automatic t_reset();
    `CHK("ctrl", ctrl_q, CTRL_RST)
    `CHK("dbg", dbg_q, DBG_RST)
    `CHK("flags", flags_q, FLAG_RST)
    `CHK("state", state_q, ST_IDLE)
    rd(ADDR_STATUS, rv);
    `CHK("status", rv, {STATUS_PAD, CODE_IDLE})
    $display("test reset done");
  endtask

  // Read/write bits keep data, reserved bits drop it
  task automatic t_rw();
    // Ones in reserved bits on purpose, to probe the zero read-back
    wr(ADDR_CTRL, 8'hfa);
    `CHK("ctrl", ctrl_q, 8'h0a)
    rd(ADDR_CTRL, rv);
    `CHK("ctrl rd", rv, 8'h0a)
    // Same register on both lanes: lane 0 is the one that lands
    wr2(ADDR_CTRL, 8'h04, ADDR_CTRL, 8'h08);
    `CHK("ctrl lanes", ctrl_q, 8'h04)
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_DBG, 8'hff);
    rd(ADDR_DBG, rv);
    `CHK("dbg rd", rv, 8'h01)
    wr(3'h6, 8'hff);
    rd(3'h6, rv);
    `CHK("unmapped", rv, UNMAPPED_VAL)
    $display("test rw done");
  endtask

  // Status follows the state machine, never shows code 3
  task automatic t_status();
    // A defined code with zero padding, so only the discard is probed
    wr(ADDR_STATUS, 8'h02);
    rd(ADDR_STATUS, rv);
    `CHK("status wr", rv, {STATUS_PAD, CODE_IDLE})
    wr(ADDR_CTRL, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("state run", state_q, ST_RUN)
    rd(ADDR_STATUS, rv);
    `CHK("status run", rv, {STATUS_PAD, CODE_RUN})
    wr(ADDR_CTRL, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1;
    rd(ADDR_STATUS, rv);
    `CHK("status halt", rv, {STATUS_PAD, CODE_HALT})
    wr(ADDR_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("state idle", state_q, ST_IDLE)
    $display("test status done");
  endtask

  // Write-only command: pulse checked, read data not judged
  task automatic t_cmd();
    wr(ADDR_CMD, 8'h02);
    `CHK("kick on", kick, 1'b1)
    @(posedge sys_clk);
    #1;
    `CHK("kick off", kick, 1'b0)
    rd(ADDR_CMD, rv);
    $display("test cmd done");
  endtask

  // Set and clear aliases over one shared state
  task automatic t_alias();
    wr(ADDR_FLAG_SET, 8'h3c);
    `CHK("set", flags_q, 8'h3c)
    wr(ADDR_FLAG_CLR, 8'h14);
    `CHK("clr", flags_q, 8'h28)
    wr(ADDR_FLAG_SET, 8'h00);
    wr(ADDR_FLAG_CLR, 8'h00);
    `CHK("zero", flags_q, 8'h28)
    rd(ADDR_FLAG_SET, rv);
    rd(ADDR_FLAG_CLR, rv2);
    `CHK("set rd", rv, 8'h28)
    `CHK("clr rd", rv2, 8'h28)
    wr2(ADDR_FLAG_SET, 8'h83, ADDR_FLAG_CLR, 8'h09);
    `CHK("race", flags_q, 8'ha2)
    $display("test alias done");
  endtask

  // Soft reset restores all but the debug control
  task automatic t_soft();
    wr(ADDR_DBG, 8'h01);
    wr(ADDR_CTRL, 8'h05);
    repeat (2) @(posedge sys_clk);
    wr(ADDR_CMD, 8'h01);
    `CHK("ctrl", ctrl_q, CTRL_RST)
    `CHK("flags", flags_q, FLAG_RST)
    `CHK("state", state_q, ST_IDLE)
    `CHK("dbg kept", dbg_q, 8'h01)
    // Debug write racing the soft reset still lands
    wr2(ADDR_CMD, 8'h01, ADDR_DBG, 8'h00);
    `CHK("dbg race", dbg_q, 8'h00)
    $display("test soft reset done");
  endtask

  // ----------------------------------------------------------------------
  // Closing and timeout
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Run needs about 85 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    sys_clk     = 1'b0;
    rst         = 1'b1;
    req         = '0;
    num_errors  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_rw();
    t_status();
    t_cmd();
    t_alias();
    t_soft();
    close_out();
  end

endmodule // rab_regs_tb
